// File: coc_defs.svh
// constants for the comparator output conditioning block
`ifndef COC_DEFS_SVH
`define COC_DEFS_SVH
`define COC_STRETCH_CYCLES 2'd3
`define COC_FILTER_CYCLES 2'd3
`define COC_DAC_WIDTH 12
`define COC_DAC_RESET 12'h000
`define COC_REF_EXTERNAL 2'b01
`define COC_REF_INTERNAL 2'b10
`define COC_REF_SUPPLY 2'b11
`endif

// File: coc_pkg.sv
// types for the comparator output conditioning block
package coc_pkg;
	typedef enum logic [2:0] {
		COC_STR_IDLE = 3'b001,
		COC_STR_HOLD = 3'b010,
		COC_STR_WAIT = 3'b100
	} coc_str_state_t;
	typedef enum logic [1:0] {
		COC_REF_NONE = 2'b00,
		COC_REF_EXT = 2'b01,
		COC_REF_INT = 2'b10,
		COC_REF_ANALOG_SUPPLY_REFERENCE = 2'b11
	} coc_ref_t;
endpackage : coc_pkg

// File: coc_stage_if.sv
// carries the signal between stretcher and filter
`timescale 1ns/1ns
interface coc_stage_if;
	logic stretched;
	modport src (output stretched);
	modport dst (input stretched);
endinterface : coc_stage_if

// File: coc_stretch.sv
// pulse stretcher: asynchronous catch, held at least three system clocks
`timescale 1ns/1ns
`include "coc_defs.svh"
module coc_stretch
	import coc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic event_in,
	coc_stage_if.src out
);
	logic caught;
	logic clr;
	logic [1:0] cnt;
	logic [2:0] sync;
	logic live;
	coc_str_state_t state;
	coc_str_state_t next_state;

	// asynchronous set captures pulses shorter than a clock
	always_ff @(posedge clk or posedge event_in or negedge rst_n) begin
		if (!rst_n)
			caught <= 1'b0;
		else if (event_in)
			caught <= 1'b1;
		else if (clr && ce)
			caught <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sync <= 3'h0;
		else if (ce)
			sync <= {sync[1:0], caught};
	end
	assign live = sync[2] & sync[1];

	always_comb begin
		next_state = state;
		case (state)
			COC_STR_IDLE: if (live) next_state = COC_STR_HOLD;
			COC_STR_HOLD: if (cnt == `COC_STRETCH_CYCLES - 2'd1) next_state = COC_STR_WAIT;
			COC_STR_WAIT: if (!live) next_state = COC_STR_IDLE;
			default: next_state = COC_STR_IDLE;
		endcase
	end
	assign clr = (state == COC_STR_WAIT) & ~event_in;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= COC_STR_IDLE;
			cnt <= 2'h0;
		end else if (ce) begin
			state <= next_state;
			cnt <= (state == COC_STR_HOLD) ? cnt + 2'd1 : 2'd0;
		end
	end
	// output held high from catch through the counted hold
	assign out.stretched = caught | (state != COC_STR_IDLE);
endmodule : coc_stretch

// File: coc_filter.sv
// glitch filter: level must be stable three selected clocks to pass
`timescale 1ns/1ns
`include "coc_defs.svh"
module coc_filter
	import coc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic enable,
	coc_stage_if.dst in,
	output logic filt
);
	logic [1:0] run;
	logic cand;
	logic passed;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= 2'h0;
			cand <= 1'b0;
			passed <= 1'b0;
		end else if (ce && tick) begin
			if (in.stretched != cand) begin
				cand <= in.stretched;
				run <= 2'd1;
			end else if (run != `COC_FILTER_CYCLES) begin
				run <= run + 2'd1;
			end
			if (in.stretched == cand && run >= `COC_FILTER_CYCLES - 2'd1)
				passed <= cand;
		end
	end
	assign filt = enable ? passed : in.stretched;
endmodule : coc_filter

// File: coc_top.sv
// top of the comparator output conditioning path
// Notes on behaviour
// - selectable inversion of raw comparator output
// - stretcher sets asynchronously, holds three clocks
// - stretcher feeds the digital filter
// - filter bypassed unless enabled
// - filter samples on selected clock
// - new level passes after three stable clocks
// - output drives several uses at once
// - threshold crossing can wake the system
// - twelve-bit threshold code per comparator
// - external or internal reference select
// - range bit picks analog supply reference on the internal path
// - output enable routes DAC to pin
`timescale 1ns/1ns
`include "coc_defs.svh"
module coc_top
	import coc_pkg::*;
#(
	parameter int DAC_WIDTH = `COC_DAC_WIDTH
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic CMP_RAW,
	input wire logic FILTER_CLK_ALT,
	input wire logic POLARITY_INVERT,
	input wire logic FILTER_ENABLE_BIT,
	input wire logic FILTER_CLOCK_SELECT,
	input wire logic EXTERNAL_REFERENCE_SELECT,
	input wire logic RANGE_SELECT,
	input wire logic DAC_OUTPUT_ENABLE,
	input wire logic [DAC_WIDTH-1:0] COMPARATOR_THRESHOLD_VALUE_REG,
	input wire logic DAC_LOAD,
	input wire logic INT_ENABLE,
	input wire logic TRIG_ENABLE,
	input wire logic PULSE_TRUNC_ENABLE,
	input wire logic PERIOD_TRUNC_ENABLE,
	input wire logic FAULT_ENABLE,
	input wire logic WAKE_ENABLE,
	output logic CMP_OUT,
	output logic INT_REQ,
	output logic ADC_TRIGGER,
	output logic PWM_PULSE_TRUNC,
	output logic PWM_PERIOD_TRUNC,
	output logic PWM_FAULT,
	output logic WAKE_REQ,
	output logic [DAC_WIDTH-1:0] DAC_CODE,
	output logic [1:0] DAC_REF_SEL,
	output logic DAC_OUTPUT_PIN_EN
);
	coc_stage_if stage ();
	logic polar;
	logic filt;
	logic filt_d;
	logic rise;
	logic [2:0] alt_sync;
	logic alt_prev;
	logic tick;
	coc_ref_t ref_sel;

	////////////////////////////////////////////////////////////////////////
	// polarity ahead of every digital stage
	assign polar = CMP_RAW ^ POLARITY_INVERT;

	coc_stretch u_stretch (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.ce(CE),
		.event_in(polar),
		.out(stage)
	);

	////////////////////////////////////////////////////////////////////////
	// alternate filter clock arrives from outside, so it is synchronised
	// and turned into a tick; agreement of stages two and three counts
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			alt_sync <= 3'h0;
			alt_prev <= 1'b0;
		end else if (CE) begin
			alt_sync <= {alt_sync[1:0], FILTER_CLK_ALT};
			if (alt_sync[2] == alt_sync[1])
				alt_prev <= alt_sync[2];
		end
	end
	assign tick = FILTER_CLOCK_SELECT ?
		(alt_sync[2] == alt_sync[1]) & alt_sync[2] & ~alt_prev : 1'b1;

	coc_filter u_filter (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.ce(CE),
		.tick(tick),
		.enable(FILTER_ENABLE_BIT),
		.in(stage),
		.filt(filt)
	);

	////////////////////////////////////////////////////////////////////////
	// reference selection; analog supply only meaningful on internal path
	assign ref_sel = EXTERNAL_REFERENCE_SELECT ? COC_REF_EXT :
		(RANGE_SELECT ? COC_REF_ANALOG_SUPPLY_REFERENCE : COC_REF_INT);
	assign rise = filt & ~filt_d;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			filt_d <= 1'b0;
			CMP_OUT <= 1'b0;
			INT_REQ <= 1'b0;
			ADC_TRIGGER <= 1'b0;
			PWM_PULSE_TRUNC <= 1'b0;
			PWM_PERIOD_TRUNC <= 1'b0;
			PWM_FAULT <= 1'b0;
			WAKE_REQ <= 1'b0;
			DAC_CODE <= `COC_DAC_RESET;
			DAC_REF_SEL <= `COC_REF_INTERNAL;
			DAC_OUTPUT_PIN_EN <= 1'b0;
		end else if (CE) begin
			filt_d <= filt;
			CMP_OUT <= filt;
			// all uses may be active together
			INT_REQ <= rise & INT_ENABLE;
			ADC_TRIGGER <= rise & TRIG_ENABLE;
			PWM_PULSE_TRUNC <= filt & PULSE_TRUNC_ENABLE;
			PWM_PERIOD_TRUNC <= filt & PERIOD_TRUNC_ENABLE;
			// fault latches until the enable is dropped
			PWM_FAULT <= FAULT_ENABLE & (PWM_FAULT | filt);
			WAKE_REQ <= filt & WAKE_ENABLE;
			if (DAC_LOAD)
				DAC_CODE <= COMPARATOR_THRESHOLD_VALUE_REG;
			DAC_REF_SEL <= ref_sel;
			// one enable per comparator; exclusivity is left to software
			DAC_OUTPUT_PIN_EN <= DAC_OUTPUT_ENABLE;
		end
	end
endmodule : coc_top

// File: coc_cmp_model.sv
// comparator model: raw level plus free-running alternate filter clock
`timescale 1ns/1ns
module coc_cmp_model (
	output logic raw,
	output logic alt_clk
);
	initial begin
		raw = 1'b0;
		alt_clk = 1'b0;
		forever #50 alt_clk = ~alt_clk;
	end
	// analog timing: a pulse ignores the system clock, so it can be far narrower
	task automatic fire(input int w);
		raw = 1'b1;
		#w raw = 1'b0;
	endtask : fire
endmodule : coc_cmp_model

// File: coc_top_chk.sv
// port assertions for the conditioning block
`timescale 1ns/1ns
module coc_top_chk #(
	parameter int DAC_WIDTH = 12
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic CMP_OUT,
	input wire logic INT_REQ,
	input wire logic FAULT_ENABLE,
	input wire logic PWM_FAULT,
	input wire logic EXTERNAL_REFERENCE_SELECT,
	input wire logic RANGE_SELECT,
	input wire logic DAC_OUTPUT_ENABLE,
	input wire logic DAC_OUTPUT_PIN_EN,
	input wire logic DAC_LOAD,
	input wire logic [DAC_WIDTH-1:0] COMPARATOR_THRESHOLD_VALUE_REG,
	input wire logic [DAC_WIDTH-1:0] DAC_CODE,
	input wire logic [1:0] DAC_REF_SEL
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	AST_STRETCH: assert property ($rose(CMP_OUT) |-> CMP_OUT [*3])
		else $error("output pulse shorter than three clocks");
	AST_INT_PULSE: assert property (INT_REQ |=> !INT_REQ)
		else $error("interrupt request longer than one cycle");
	AST_INT_LEVEL: assert property (INT_REQ |-> CMP_OUT)
		else $error("interrupt request without output");
	AST_FAULT: assert property (CE && !FAULT_ENABLE |=> !PWM_FAULT)
		else $error("fault latch not cleared");
	AST_EXT: assert property (CE && EXTERNAL_REFERENCE_SELECT |=> DAC_REF_SEL == 2'b01)
		else $error("external reference not selected");
	AST_RANGE: assert property (CE && !EXTERNAL_REFERENCE_SELECT && RANGE_SELECT
		|=> DAC_REF_SEL == 2'b11) else $error("supply reference not selected");
	AST_PIN: assert property (CE |=> DAC_OUTPUT_PIN_EN == $past(DAC_OUTPUT_ENABLE))
		else $error("pin enable wrong");
	AST_DAC: assert property (CE && DAC_LOAD
		|=> DAC_CODE == $past(COMPARATOR_THRESHOLD_VALUE_REG)) else $error("code not loaded");
endmodule : coc_top_chk
bind coc_top coc_top_chk #(.DAC_WIDTH(DAC_WIDTH)) coc_top_chk_i (.CLK_SYS, .RST_N, .CE,
	.CMP_OUT, .INT_REQ, .FAULT_ENABLE, .PWM_FAULT, .EXTERNAL_REFERENCE_SELECT, .RANGE_SELECT,
	.DAC_OUTPUT_ENABLE, .DAC_OUTPUT_PIN_EN, .DAC_LOAD, .COMPARATOR_THRESHOLD_VALUE_REG,
	.DAC_CODE, .DAC_REF_SEL);

// File: coc_top_tb.sv
// self-checking bench for the conditioning block
`timescale 1ns/1ns
module coc_top_tb;
	logic CLK_SYS, RST_N, CE, CMP_RAW, FILTER_CLK_ALT, POLARITY_INVERT;
	logic FILTER_ENABLE_BIT, FILTER_CLOCK_SELECT, EXTERNAL_REFERENCE_SELECT, RANGE_SELECT;
	logic DAC_OUTPUT_ENABLE, DAC_LOAD, INT_ENABLE, TRIG_ENABLE, PULSE_TRUNC_ENABLE;
	logic PERIOD_TRUNC_ENABLE, FAULT_ENABLE, WAKE_ENABLE, CMP_OUT, INT_REQ, ADC_TRIGGER;
	logic PWM_PULSE_TRUNC, PWM_PERIOD_TRUNC, PWM_FAULT, WAKE_REQ, DAC_OUTPUT_PIN_EN;
	logic [11:0] COMPARATOR_THRESHOLD_VALUE_REG, DAC_CODE;
	logic [1:0] DAC_REF_SEL;
	int error_cnt, checks_done, n_out, n_int, n_trg;
	coc_cmp_model coc_cmp_model_i (.raw(CMP_RAW), .alt_clk(FILTER_CLK_ALT));
	coc_top #(.DAC_WIDTH(12)) coc_top_i (.CLK_SYS, .RST_N, .CE, .CMP_RAW, .FILTER_CLK_ALT,
		.POLARITY_INVERT, .FILTER_ENABLE_BIT, .FILTER_CLOCK_SELECT, .EXTERNAL_REFERENCE_SELECT,
		.RANGE_SELECT, .DAC_OUTPUT_ENABLE, .COMPARATOR_THRESHOLD_VALUE_REG, .DAC_LOAD,
		.INT_ENABLE, .TRIG_ENABLE, .PULSE_TRUNC_ENABLE, .PERIOD_TRUNC_ENABLE, .FAULT_ENABLE,
		.WAKE_ENABLE, .CMP_OUT, .INT_REQ, .ADC_TRIGGER, .PWM_PULSE_TRUNC, .PWM_PERIOD_TRUNC,
		.PWM_FAULT, .WAKE_REQ, .DAC_CODE, .DAC_REF_SEL, .DAC_OUTPUT_PIN_EN);
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// counts high cycles of CMP_OUT, INT_REQ and ADC_TRIGGER, sampled just after each edge
	task automatic run(input int n);
		n_out = 0;
		n_int = 0;
		n_trg = 0;
		repeat (n) begin
			@(posedge CLK_SYS);
			#1;
			n_out += int'(CMP_OUT === 1'b1);
			n_int += int'(INT_REQ === 1'b1);
			n_trg += int'(ADC_TRIGGER === 1'b1);
		end
	endtask : run
	task automatic print_verdict;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end
	// whole sequence needs about 340 clocks
	initial begin
		#20000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		{RST_N, CE, POLARITY_INVERT, FILTER_ENABLE_BIT, FILTER_CLOCK_SELECT, DAC_LOAD} = '0;
		{EXTERNAL_REFERENCE_SELECT, RANGE_SELECT, DAC_OUTPUT_ENABLE, INT_ENABLE} = '0;
		{TRIG_ENABLE, PULSE_TRUNC_ENABLE, PERIOD_TRUNC_ENABLE, FAULT_ENABLE, WAKE_ENABLE} = '0;
		COMPARATOR_THRESHOLD_VALUE_REG = 12'h000;
		run(3);
		chk(DAC_REF_SEL, 2'b10);
		chk(CMP_OUT, 1'b0);
		{RST_N, CE, INT_ENABLE, TRIG_ENABLE} = '1;
		run(2);
		coc_cmp_model_i.fire(2);
		run(12);
		chk(n_out >= 3, 1'b1);
		chk(n_int + 16 * n_trg, 12'h011);
		{POLARITY_INVERT, PULSE_TRUNC_ENABLE, PERIOD_TRUNC_ENABLE, FAULT_ENABLE, WAKE_ENABLE} = '1;
		run(10);
		chk({CMP_OUT, PWM_PULSE_TRUNC, PWM_PERIOD_TRUNC, PWM_FAULT, WAKE_REQ}, 5'h1f);
		{POLARITY_INVERT, FAULT_ENABLE} = 2'b00;
		run(10);
		chk({CMP_OUT, PWM_FAULT, WAKE_REQ}, 3'h0);
		{FILTER_ENABLE_BIT, FILTER_CLOCK_SELECT} = 2'b11;
		run(40);
		coc_cmp_model_i.fire(2);
		run(60);
		chk(n_out, 0);
		fork
			coc_cmp_model_i.fire(800);
			run(70);
		join
		chk(n_out > 0, 1'b1);
		COMPARATOR_THRESHOLD_VALUE_REG = 12'habc;
		{DAC_LOAD, EXTERNAL_REFERENCE_SELECT, DAC_OUTPUT_ENABLE} = '1;
		run(1);
		DAC_LOAD = 1'b0;
		run(1);
		chk(DAC_CODE, 12'habc);
		chk(DAC_REF_SEL, 2'b01);
		chk(DAC_OUTPUT_PIN_EN, 1'b1);
		{EXTERNAL_REFERENCE_SELECT, RANGE_SELECT} = 2'b01;
		run(2);
		chk(DAC_REF_SEL, 2'b11);
		// filter on the system clock: the long pulse must have drained first
		FILTER_CLOCK_SELECT = 1'b0;
		run(80);
		chk(CMP_OUT, 1'b0);
		coc_cmp_model_i.fire(2);
		run(20);
		chk(n_out >= 3, 1'b1);
		print_verdict();
	end
endmodule : coc_top_tb
